//--- logic/urt_pkg.sv
`default_nettype none
package urt_pkg;
  // ==========================================================================
  // Register byte addresses.
  localparam logic [7:0] ADDR_RX_HOLDING = 8'h00;
  localparam logic [7:0] ADDR_IRQ_IDENT = 8'h04;
  localparam logic [7:0] ADDR_LINE_STATE = 8'h08;
  localparam logic [7:0] ADDR_MODEM_STATE = 8'h0C;
  localparam logic [7:0] ADDR_SECOND_FEATURE = 8'h10;
  localparam logic [7:0] ADDR_TIMEOUT_LOW = 8'h14;
  localparam logic [7:0] ADDR_TIMEOUT_HIGH = 8'h18;
  localparam logic [7:0] ADDR_TRIGGER_LEVEL = 8'h1C;
  localparam logic [7:0] ADDR_BAUD_DIV = 8'h20;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h24;
  localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h28;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h2C;
  localparam logic [7:0] ADDR_RX_LEVEL = 8'h30;
  // ==========================================================================
  // Field positions.
  localparam int PERIODIC_MODE_BIT = 6;
  localparam int RX_TRIG_LSB = 0;
  localparam int TX_TRIG_LSB = 8;
  localparam int LSR_DATA_READY = 0;
  localparam int LSR_OVERRUN = 1;
  localparam int LSR_FRAME_ERR = 2;
  localparam int LSR_TRIG_ODD = 7;
  localparam int MSR_DELTA_CTS = 0;
  localparam int MSR_CTS = 4;
  localparam int IRQ_TIMEOUT = 0;
  localparam int IRQ_RX_CHAR = 1;
  localparam int IRQ_OVERRUN = 2;
  localparam int IRQ_FRAME_ERR = 3;
  localparam int IRQ_MODEM = 4;
  // ==========================================================================
  // Sizes, reset values and codes.
  localparam int FIFO_DEPTH = 64;
  localparam int PTR_W = 6;
  localparam int IRQ_W = 5;
  localparam int TRIG_W = 6;
  localparam logic [7:0] TIMEOUT_LOW_RST = 8'h40;
  localparam logic [7:0] TIMEOUT_HIGH_RST = 8'h00;
  localparam logic [15:0] BAUD_DIV_RST = 16'h0056;
  localparam logic [TRIG_W-1:0] RX_TRIG_RST = 6'h01;
  localparam logic [TRIG_W-1:0] TX_TRIG_RST = 6'h01;
  localparam logic [2:0] IIR_NONE = 3'h0;
  localparam logic [2:0] IIR_TIMEOUT = 3'h6;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} urt_rx_state_t;
endpackage
`default_nettype wire

//--- logic/urt_fifo_mem.sv
`timescale 1ns/100ps
`default_nettype none
// ============================================================================
// Receive FIFO storage: one write port, read data from a register.
module urt_fifo_mem (
  input wire logic clock_i,
  input wire logic wr_en_i,
  input wire logic [5:0] wr_addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [5:0] rd_addr_i,
  output logic [7:0] rd_data_o
);
  logic [7:0] mem [0:63];

  // Storage needs no reset; the pointers say which words are valid.
  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    rd_data_o <= mem[rd_addr_i];
  end
endmodule // urt_fifo_mem
`default_nettype wire

//--- logic/urt_rx_timeout.sv
`timescale 1ns/100ps
`default_nettype none
module urt_rx_timeout (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic rx_i,
  input wire logic cts_n_i,
  input wire logic [6:0] tx_space_i,
  output logic irq_o,
  output logic rx_dma_req_o,
  output logic tx_dma_req_o
);
  // ==========================================================================
  // Pin synchronisers.
  logic rx_meta, rx_sync, cts_meta, cts_sync, cts_prev;

  // Two stages keep metastability away from the receiver and the modem flag.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_meta <= 1'b1;
      rx_sync <= 1'b1;
      cts_meta <= 1'b1;
      cts_sync <= 1'b1;
      cts_prev <= 1'b1;
    end else begin
      rx_meta <= rx_i;
      rx_sync <= rx_meta;
      cts_meta <= cts_n_i;
      cts_sync <= cts_meta;
      cts_prev <= cts_sync;
    end
  end

  // ==========================================================================
  // Software registers and bus decode.
  logic periodic_mode, next_periodic_mode;
  logic [7:0] tout_low, next_tout_low, tout_high, next_tout_high;
  localparam int TRIG_W_L = urt_pkg::TRIG_W;
  logic [TRIG_W_L-1:0] rx_trig, next_rx_trig, tx_trig, next_tx_trig;
  logic [15:0] baud_div, next_baud_div;
  logic [4:0] irq_en, next_irq_en;
  logic rd_rhr, rd_iir, rd_lsr, rd_msr, clr_wr;
  logic [15:0] tout_val;

  assign rd_rhr = rd_i && (addr_i == urt_pkg::ADDR_RX_HOLDING);
  assign rd_iir = rd_i && (addr_i == urt_pkg::ADDR_IRQ_IDENT);
  assign rd_lsr = rd_i && (addr_i == urt_pkg::ADDR_LINE_STATE);
  assign rd_msr = rd_i && (addr_i == urt_pkg::ADDR_MODEM_STATE);
  assign clr_wr = wr_i && (addr_i == urt_pkg::ADDR_IRQ_CLEAR);
  assign tout_val = {tout_high, tout_low};

  // Register writes; unmapped or read-only addresses ignore the write.
  always_comb begin
    next_periodic_mode = periodic_mode;
    next_tout_low = tout_low;
    next_tout_high = tout_high;
    next_rx_trig = rx_trig;
    next_tx_trig = tx_trig;
    next_baud_div = baud_div;
    next_irq_en = irq_en;
    if (wr_i) begin
      case (addr_i)
        urt_pkg::ADDR_SECOND_FEATURE: begin
          next_periodic_mode = wdata_i[urt_pkg::PERIODIC_MODE_BIT];
        end
        urt_pkg::ADDR_TIMEOUT_LOW: next_tout_low = wdata_i[7:0];
        urt_pkg::ADDR_TIMEOUT_HIGH: next_tout_high = wdata_i[7:0];
        urt_pkg::ADDR_TRIGGER_LEVEL: begin
          next_rx_trig = wdata_i[urt_pkg::RX_TRIG_LSB +: TRIG_W_L];
          next_tx_trig = wdata_i[urt_pkg::TX_TRIG_LSB +: TRIG_W_L];
        end
        urt_pkg::ADDR_BAUD_DIV: next_baud_div = wdata_i[15:0];
        urt_pkg::ADDR_IRQ_ENABLE: next_irq_en = wdata_i[4:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      periodic_mode <= 1'b0;
      tout_low <= urt_pkg::TIMEOUT_LOW_RST;
      tout_high <= urt_pkg::TIMEOUT_HIGH_RST;
      rx_trig <= urt_pkg::RX_TRIG_RST;
      tx_trig <= urt_pkg::TX_TRIG_RST;
      baud_div <= urt_pkg::BAUD_DIV_RST;
      irq_en <= 5'h00;
    end else begin
      periodic_mode <= next_periodic_mode;
      tout_low <= next_tout_low;
      tout_high <= next_tout_high;
      rx_trig <= next_rx_trig;
      tx_trig <= next_tx_trig;
      baud_div <= next_baud_div;
      irq_en <= next_irq_en;
    end
  end

  // ==========================================================================
  // Serial receiver: 8 data bits, one stop bit, sampled mid-bit.
  urt_pkg::urt_rx_state_t rx_state, next_rx_state;
  logic [15:0] div_cnt, next_div_cnt;
  logic [2:0] bit_cnt, next_bit_cnt;
  logic [7:0] shift, next_shift;
  logic push, frame_evt;

  always_comb begin
    next_rx_state = rx_state;
    next_div_cnt = div_cnt;
    next_bit_cnt = bit_cnt;
    next_shift = shift;
    push = 1'b0;
    frame_evt = 1'b0;
    case (rx_state)
      urt_pkg::RX_IDLE: begin
        if (!rx_sync) begin
          next_rx_state = urt_pkg::RX_START;
          next_div_cnt = baud_div >> 1;
        end
      end
      urt_pkg::RX_START: begin
        if (div_cnt == 16'h0000) begin
          next_div_cnt = baud_div - 16'h0001;
          next_bit_cnt = 3'h0;
          // A start bit gone high at mid-bit was a glitch.
          next_rx_state = rx_sync ? urt_pkg::RX_IDLE : urt_pkg::RX_DATA;
        end else begin
          next_div_cnt = div_cnt - 16'h0001;
        end
      end
      urt_pkg::RX_DATA: begin
        if (div_cnt == 16'h0000) begin
          next_div_cnt = baud_div - 16'h0001;
          next_shift = {rx_sync, shift[7:1]};
          next_bit_cnt = bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            next_rx_state = urt_pkg::RX_STOP;
          end
        end else begin
          next_div_cnt = div_cnt - 16'h0001;
        end
      end
      urt_pkg::RX_STOP: begin
        if (div_cnt == 16'h0000) begin
          next_rx_state = urt_pkg::RX_IDLE;
          push = rx_sync;
          frame_evt = !rx_sync;
        end else begin
          next_div_cnt = div_cnt - 16'h0001;
        end
      end
      default: next_rx_state = urt_pkg::RX_IDLE;
    endcase
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_state <= urt_pkg::RX_IDLE;
      div_cnt <= 16'h0000;
      bit_cnt <= 3'h0;
      shift <= 8'h00;
    end else begin
      rx_state <= next_rx_state;
      div_cnt <= next_div_cnt;
      bit_cnt <= next_bit_cnt;
      shift <= next_shift;
    end
  end

  // ==========================================================================
  // Receive FIFO pointers; a full FIFO drops the new character.
  logic [5:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [6:0] level, next_level;
  logic pop, wr_en, overrun_evt;
  logic [7:0] head_data;

  assign pop = rd_rhr && (level != 7'h00);
  assign wr_en = push && (level != 7'(urt_pkg::FIFO_DEPTH));
  assign overrun_evt = push && !wr_en;

  always_comb begin
    next_wr_ptr = wr_en ? wr_ptr + 6'h01 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 6'h01 : rd_ptr;
    next_level = level + {6'h00, wr_en} - {6'h00, pop};
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_ptr <= 6'h00;
      rd_ptr <= 6'h00;
      level <= 7'h00;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      level <= next_level;
    end
  end

  // Reading ahead at the next pointer lets back-to-back pops see fresh data.
  urt_fifo_mem urt_fifo_mem_inst (
    .clock_i(clock_i),
    .wr_en_i(wr_en),
    .wr_addr_i(wr_ptr),
    .wr_data_i(shift),
    .rd_addr_i(next_rd_ptr),
    .rd_data_o(head_data)
  );

  // ==========================================================================
  // Timeout counter, counted in bit times of the current baud divisor.
  logic [15:0] tick_cnt, next_tick_cnt, tmo_cnt, next_tmo_cnt;
  logic tick, next_tick, tmo_pending, next_tmo_pending, expire, side_read;

  assign side_read = rd_rhr || rd_msr || rd_lsr;
  assign expire = tick && (tout_val != 16'h0000) && ((tmo_cnt + 16'h0001) >= tout_val);

  always_comb begin
    next_tick = (tick_cnt == 16'h0000);
    next_tick_cnt = next_tick ? baud_div - 16'h0001 : tick_cnt - 16'h0001;
    next_tmo_cnt = tmo_cnt;
    next_tmo_pending = tmo_pending;
    if (periodic_mode) begin
      // Free-running period; a new character restarts it.
      if (push) begin
        next_tmo_cnt = 16'h0000;
      end else if (tick) begin
        next_tmo_cnt = expire ? 16'h0000 : tmo_cnt + 16'h0001;
      end
    end else begin
      // Idle time counts only while characters wait in the FIFO.
      if ((level == 7'h00) || push || side_read) begin
        next_tmo_cnt = 16'h0000;
      end else if (tick) begin
        next_tmo_cnt = expire ? 16'h0000 : tmo_cnt + 16'h0001;
      end
    end
    // Holding, line and modem state reads drop a pending timeout in original mode, as the silicon does; ident reads drop it in both modes.
    if (rd_iir || (side_read && !periodic_mode) || (clr_wr && wdata_i[urt_pkg::IRQ_TIMEOUT])) begin
      next_tmo_pending = 1'b0;
    end
    // Expiry wins over any clear in the same cycle.
    if (expire && (periodic_mode || (level != 7'h00))) begin
      next_tmo_pending = 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tick <= 1'b0;
      tick_cnt <= 16'h0000;
      tmo_cnt <= 16'h0000;
      tmo_pending <= 1'b0;
    end else begin
      tick <= next_tick;
      tick_cnt <= next_tick_cnt;
      tmo_cnt <= next_tmo_cnt;
      tmo_pending <= next_tmo_pending;
    end
  end

  // ==========================================================================
  // Sticky event flags, line flags, interrupt and DMA requests.
  logic [4:0] sticky, next_sticky, status;
  logic overrun_flag, next_overrun_flag, frame_flag, next_frame_flag;
  logic delta_cts, next_delta_cts, trig_odd;
  logic next_irq, next_rx_dma, next_tx_dma;

  // A trigger with more than one bit set is legal but not a power of two.
  function automatic logic not_pow2(input logic [5:0] v);
    not_pow2 = (v == 6'h00) || ((v & (v - 6'h01)) != 6'h00);
  endfunction

  assign trig_odd = not_pow2(rx_trig) || not_pow2(tx_trig);
  assign status = {sticky[4:1], tmo_pending};

  always_comb begin
    next_sticky = sticky;
    if (clr_wr) begin
      next_sticky = sticky & ~wdata_i[4:0];
    end
    next_sticky[urt_pkg::IRQ_TIMEOUT] = 1'b0;
    next_sticky[urt_pkg::IRQ_RX_CHAR] = next_sticky[urt_pkg::IRQ_RX_CHAR] | wr_en;
    next_sticky[urt_pkg::IRQ_OVERRUN] = next_sticky[urt_pkg::IRQ_OVERRUN] | overrun_evt;
    next_sticky[urt_pkg::IRQ_FRAME_ERR] = next_sticky[urt_pkg::IRQ_FRAME_ERR] | frame_evt;
    next_sticky[urt_pkg::IRQ_MODEM] = next_sticky[urt_pkg::IRQ_MODEM] | (cts_sync != cts_prev);
    // Line flags clear on a line state read; a new error in that cycle survives.
    next_overrun_flag = (overrun_flag && !rd_lsr) || overrun_evt;
    next_frame_flag = (frame_flag && !rd_lsr) || frame_evt;
    next_delta_cts = (delta_cts && !rd_msr) || (cts_sync != cts_prev);
    next_irq = |(status & irq_en);
    // Requests compare the raw level with the trigger, odd triggers included.
    next_rx_dma = (rx_trig != 6'h00) && (level >= {1'b0, rx_trig});
    next_tx_dma = (tx_trig != 6'h00) && (tx_space_i >= {1'b0, tx_trig});
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sticky <= 5'h00;
      overrun_flag <= 1'b0;
      frame_flag <= 1'b0;
      delta_cts <= 1'b0;
      irq_o <= 1'b0;
      rx_dma_req_o <= 1'b0;
      tx_dma_req_o <= 1'b0;
    end else begin
      sticky <= next_sticky;
      overrun_flag <= next_overrun_flag;
      frame_flag <= next_frame_flag;
      delta_cts <= next_delta_cts;
      irq_o <= next_irq;
      rx_dma_req_o <= next_rx_dma;
      tx_dma_req_o <= next_tx_dma;
    end
  end

  // ==========================================================================
  // Read data, valid in the cycle after the read strobe; unmapped reads give zero.
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (rd_i) begin
      case (addr_i)
        urt_pkg::ADDR_RX_HOLDING: next_rdata = {24'h000000, head_data};
        urt_pkg::ADDR_IRQ_IDENT: begin
          next_rdata = {28'h0000000, tmo_pending ? urt_pkg::IIR_TIMEOUT : urt_pkg::IIR_NONE,
            !tmo_pending};
        end
        urt_pkg::ADDR_LINE_STATE: begin
          next_rdata[urt_pkg::LSR_DATA_READY] = (level != 7'h00);
          next_rdata[urt_pkg::LSR_OVERRUN] = overrun_flag;
          next_rdata[urt_pkg::LSR_FRAME_ERR] = frame_flag;
          next_rdata[urt_pkg::LSR_TRIG_ODD] = trig_odd;
        end
        urt_pkg::ADDR_MODEM_STATE: begin
          next_rdata[urt_pkg::MSR_DELTA_CTS] = delta_cts;
          next_rdata[urt_pkg::MSR_CTS] = !cts_sync;
        end
        urt_pkg::ADDR_SECOND_FEATURE: next_rdata[urt_pkg::PERIODIC_MODE_BIT] = periodic_mode;
        urt_pkg::ADDR_TIMEOUT_LOW: next_rdata = {24'h000000, tout_low};
        urt_pkg::ADDR_TIMEOUT_HIGH: next_rdata = {24'h000000, tout_high};
        urt_pkg::ADDR_TRIGGER_LEVEL: begin
          next_rdata = {18'h00000, tx_trig, 2'h0, rx_trig};
        end
        urt_pkg::ADDR_BAUD_DIV: next_rdata = {16'h0000, baud_div};
        urt_pkg::ADDR_IRQ_STATUS: next_rdata = {27'h0000000, status};
        urt_pkg::ADDR_IRQ_ENABLE: next_rdata = {27'h0000000, irq_en};
        urt_pkg::ADDR_RX_LEVEL: next_rdata = {25'h0000000, level};
        default: next_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= 32'h0000_0000;
    end else begin
      rdata_o <= next_rdata;
    end
  end
endmodule // urt_rx_timeout
`default_nettype wire

//--- test/urt_rx_timeout_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Port checker for the receive timeout block.
module urt_rx_timeout_monitor (
  input wire logic clock_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic rx_i,
  input wire logic cts_n_i,
  input wire logic [6:0] tx_space_i,
  input wire logic irq_o,
  input wire logic rx_dma_req_o,
  input wire logic tx_dma_req_o
);
  logic mode_sh;
  logic [7:0] tlo_sh;
  logic [7:0] thi_sh;
  logic [5:0] rxt_sh;
  logic [5:0] txt_sh;
  logic [4:0] en_sh;
  logic [1:0] live;
  logic odd_now;
  logic tx_hit;
  // ==========================================================================
  // Shadows follow bus writes only, so a field that never updates shows on read-back.
  always_ff @(posedge clock_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_sh <= 1'b0;
      tlo_sh <= 8'h40;
      thi_sh <= 8'h00;
      rxt_sh <= 6'h01;
      txt_sh <= 6'h01;
      en_sh <= 5'h00;
      live <= 2'h0;
    end else begin
      live <= {live[0], 1'b1};
      if (wr_i && addr_i == 8'h10) mode_sh <= wdata_i[6];
      if (wr_i && addr_i == 8'h14) tlo_sh <= wdata_i[7:0];
      if (wr_i && addr_i == 8'h18) thi_sh <= wdata_i[7:0];
      if (wr_i && addr_i == 8'h1C) rxt_sh <= wdata_i[5:0];
      if (wr_i && addr_i == 8'h1C) txt_sh <= wdata_i[13:8];
      if (wr_i && addr_i == 8'h2C) en_sh <= wdata_i[4:0];
    end
  end
  // A level with more than one bit set is not a power of two.
  assign odd_now = ((rxt_sh & (rxt_sh - 6'h01)) != 6'h00) ||
    ((txt_sh & (txt_sh - 6'h01)) != 6'h00);
  assign tx_hit = (tx_space_i >= {1'b0, txt_sh}) && (txt_sh != 6'h00);
  // ==========================================================================
  // Properties.
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  property p_idle_zero; !rd_i |=> rdata_o == 32'h0; endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data not zero outside a read");
  property p_unmapped; rd_i && addr_i == 8'h3C |=> rdata_o == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ident_form;
    rd_i && addr_i == 8'h04 |=> rdata_o == 32'h1 || rdata_o == 32'hC;
  endproperty
  a_ident_form: assert property (p_ident_form) else $error("bad identity code");
  property p_mode_read; rd_i && addr_i == 8'h10 |=> rdata_o[6] == $past(mode_sh); endproperty
  a_mode_read: assert property (p_mode_read) else $error("mode bit read-back wrong");
  property p_count_low; rd_i && addr_i == 8'h14 |=> rdata_o == {24'h0, $past(tlo_sh)}; endproperty
  a_count_low: assert property (p_count_low) else $error("low count read-back wrong");
  property p_count_high; rd_i && addr_i == 8'h18 ##1 1'b1 |-> rdata_o == {24'h0, $past(thi_sh)};
  endproperty
  a_count_high: assert property (p_count_high) else $error("high count read-back wrong");
  property p_odd_flag;
    rd_i && addr_i == 8'h08 && rxt_sh != 6'h00 && txt_sh != 6'h00 |=> rdata_o[7] == $past(odd_now);
  endproperty
  a_odd_flag: assert property (p_odd_flag) else $error("trigger flag wrong");
  property p_tx_dma; live[1] |-> tx_dma_req_o == $past(tx_hit); endproperty
  a_tx_dma: assert property (p_tx_dma) else $error("transmit request wrong");
  property p_irq_follow;
    $past(rd_i) && $past(addr_i) == 8'h24 |-> irq_o == |(rdata_o[4:0] & $past(en_sh));
  endproperty
  a_irq_follow: assert property (p_irq_follow) else $error("irq not status and enable");
  property p_masked; $past(en_sh) == 5'h00 |-> !irq_o; endproperty
  a_masked: assert property (p_masked) else $error("interrupt while all masked");
  c_timeout_seen: cover property (rd_i && addr_i == 8'h04 ##1 rdata_o == 32'hC);
  c_irq_rise: cover property ($rose(irq_o));
  c_rx_dma: cover property ($rose(rx_dma_req_o));
endmodule // urt_rx_timeout_monitor
bind urt_rx_timeout urt_rx_timeout_monitor urt_rx_timeout_monitor_inst (
  .clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .rx_i(rx_i), .cts_n_i(cts_n_i), .tx_space_i(tx_space_i),
  .irq_o(irq_o), .rx_dma_req_o(rx_dma_req_o), .tx_dma_req_o(tx_dma_req_o)
);
`default_nettype wire

//--- test/urt_line_peer.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Serial line peer: idle high, sends 8N1 frames, drives clear-to-send.
module urt_line_peer (
  input wire logic clock_i,
  output logic rx_o,
  output logic cts_n_o
);
  // The line rests at its idle level between frames.
  initial begin
    rx_o = 1'b1;
    cts_n_o = 1'b1;
  end
  // One frame, LSB first; a slow peer simply passes a longer bit time.
  task automatic send(input logic [7:0] b, input int cpb);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_o <= f[i];
      repeat (cpb) @(posedge clock_i);
    end
  endtask
  task automatic set_cts(input logic active);
    cts_n_o <= ~active;
    @(posedge clock_i);
  endtask
endmodule // urt_line_peer
`default_nettype wire

//--- test/tb_urt_rx_timeout.sv
`timescale 1ns/100ps
`default_nettype none
module tb_urt_rx_timeout;
  logic clock_i;
  logic rstn_i;
  logic wr_i;
  logic rd_i;
  logic irq_o;
  logic rx_dma_req_o;
  logic tx_dma_req_o;
  logic rx_line;
  logic cts_n;
  logic [7:0] addr_i;
  logic [31:0] wdata_i;
  logic [31:0] rdata_o;
  logic [6:0] tx_space_i;
  int err_count;
  int cmp_count;
  int cyc;
  logic [7:0] ra [7] = '{8'h14, 8'h18, 8'h20, 8'h1C, 8'h10, 8'h2C, 8'h3C};
  logic [31:0] re [7] = '{32'h40, 32'h0, 32'h56, 32'h101, 32'h0, 32'h0, 32'h0};
  urt_rx_timeout urt_rx_timeout_inst (
    .clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .rx_i(rx_line), .cts_n_i(cts_n), .tx_space_i(tx_space_i),
    .irq_o(irq_o), .rx_dma_req_o(rx_dma_req_o), .tx_dma_req_o(tx_dma_req_o)
  );
  urt_line_peer urt_line_peer_inst (.clock_i(clock_i), .rx_o(rx_line), .cts_n_o(cts_n));
  // ==========================================================================
  // Clock and run limit; the whole sequence needs under two thousand cycles.
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  initial begin
    cyc = 0;
    while (cyc < 8000) begin
      @(posedge clock_i);
      cyc++;
    end
    err_count++;
    $display("[FAIL] run length expected below 8000 seen %0d", cyc);
    wrap_up();
  end
  // ==========================================================================
  // Shared tasks.
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clock_i);
    wr_i <= 1'b0;
    @(posedge clock_i);
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken mid-cycle there.
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clock_i);
    rd_i <= 1'b0;
    @(negedge clock_i);
    check($sformatf("read %h", a), exp, rdata_o);
    @(posedge clock_i);
  endtask
  // The interrupt is sampled mid-cycle, away from the edge that launches it.
  task automatic wait_irq(input logic exp, input int n);
    int i;
    i = 0;
    do begin
      @(negedge clock_i);
      i++;
    end while (irq_o !== exp && i < n);
    check("irq_o", {31'h0, exp}, {31'h0, irq_o});
    @(posedge clock_i);
  endtask
  task automatic hold_irq(input logic exp, input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      @(negedge clock_i);
      if (irq_o !== exp) bad++;
    end
    check("irq_o steady", 32'h0, 32'(bad));
    @(posedge clock_i);
  endtask
  // Margin after the stop bit covers the synchroniser and the push.
  task automatic frame(input logic [7:0] b);
    urt_line_peer_inst.send(b, 4);
    repeat (10) @(posedge clock_i);
    @(negedge clock_i);
  endtask
  // ==========================================================================
  // Main sequence.
  initial begin
    rstn_i = 1'b0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    tx_space_i = 7'h00;
    err_count = 0;
    cmp_count = 0;
    repeat (8) @(posedge clock_i);
    rstn_i <= 1'b1;
    @(posedge clock_i);
    for (int i = 0; i < 7; i++) rc(ra[i], re[i]);
    wr(8'h20, 32'h4);
    wr(8'h14, 32'h8);
    wr(8'h2C, 32'h1);
    tx_space_i <= 7'h01;
    frame(8'hA5);
    check("irq early", 32'h0, {31'h0, irq_o});
    check("rx dma", 32'h1, {31'h0, rx_dma_req_o});
    check("tx dma", 32'h1, {31'h0, tx_dma_req_o});
    wait_irq(1'b1, 80);
    rc(8'h04, 32'hC);
    rc(8'h24, 32'h2);
    hold_irq(1'b0, 16);
    wait_irq(1'b1, 80);
    rc(8'h08, 32'h1);
    rc(8'h24, 32'h2);
    rc(8'h00, 32'hA5);
    hold_irq(1'b0, 80);
    // Periodic mode fires with an empty queue and ignores line state reads.
    wr(8'h10, 32'h40);
    rc(8'h10, 32'h40);
    wait_irq(1'b1, 80);
    rc(8'h04, 32'hC);
    hold_irq(1'b0, 8);
    wait_irq(1'b1, 80);
    rc(8'h08, 32'h0);
    rc(8'h24, 32'h3);
    wr(8'h18, 32'h1);
    wr(8'h14, 32'h2);
    wr(8'h2C, 32'h0);
    hold_irq(1'b0, 4);
    wr(8'h28, 32'h3);
    rc(8'h24, 32'h0);
    wr(8'h2C, 32'h1);
    hold_irq(1'b0, 200);
    wait_irq(1'b1, 1300);
    // Clearing a stale timeout with an empty queue.
    wr(8'h10, 32'h0);
    wr(8'h18, 32'hFF);
    wr(8'h14, 32'hFF);
    wr(8'h10, 32'h40);
    rc(8'h04, 32'hC);
    wr(8'h10, 32'h0);
    rc(8'h18, 32'hFF);
    hold_irq(1'b0, 100);
    // Request levels at power-of-two trigger settings; an odd setting shows in the line state.
    wr(8'h10, 32'h40);
    wr(8'h1C, 32'h402);
    tx_space_i <= 7'h03;
    frame(8'h3C);
    check("rx dma", 32'h0, {31'h0, rx_dma_req_o});
    check("tx dma", 32'h0, {31'h0, tx_dma_req_o});
    @(posedge clock_i);
    tx_space_i <= 7'h04;
    frame(8'hC3);
    check("rx dma", 32'h1, {31'h0, rx_dma_req_o});
    check("tx dma", 32'h1, {31'h0, tx_dma_req_o});
    @(posedge clock_i);
    rc(8'h08, 32'h1);
    wr(8'h1C, 32'h403);
    rc(8'h08, 32'h81);
    wr(8'h1C, 32'h420);
    @(negedge clock_i);
    check("rx dma", 32'h0, {31'h0, rx_dma_req_o});
    @(posedge clock_i);
    rc(8'h00, 32'h3C);
    rc(8'h00, 32'hC3);
    urt_line_peer_inst.set_cts(1'b1);
    repeat (4) @(posedge clock_i);
    rc(8'h0C, 32'h11);
    rc(8'h0C, 32'h10);
    wrap_up();
  end
endmodule // tb_urt_rx_timeout
`default_nettype wire
